//--- shared/wdc_pkg.sv
/*
  Constants and types shared by the watchdog mode control block.
  Assumes a single 100 MHz system clock and a synchronous reset.
*/
package wdc_pkg;

  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] CTRL_ADDR = 8'h60;
  localparam logic [7:0] STAT_ADDR = 8'h64;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ********************************
  // Control register fields
  // ********************************
  localparam int FLAG_BIT = 7;
  localparam int IE_BIT = 6;
  localparam int P3_BIT = 5;
  localparam int UNL_BIT = 4;
  localparam int RSTEN_BIT = 3;
  localparam int P_HI = 2;
  localparam int P_LO = 0;

  // ********************************
  // Status register fields
  // ********************************
  localparam int FUSE_BIT = 0;
  localparam int IRQ_BIT = 1;

  // ********************************
  // Timing
  // ********************************
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int BASE_TICKS = 2048;
  localparam logic [3:0] MAX_SEL = 4'h9;

  // ********************************
  // Watchdog modes
  // ********************************
  typedef enum logic [3:0] {
    MODE_STOP = 4'h1,
    MODE_IRQ = 4'h2,
    MODE_RST = 4'h4,
    MODE_BOTH = 4'h8
  } wdc_mode_t;

endpackage

//--- shared/wdc_reg_if.sv
/*
  Internal register access carrier between bus slave and core.
  Assumes both ends run on clk_sys; wr is a one-cycle strobe.
*/
`timescale 1ns/1ns
interface wdc_reg_if;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] ctrl;
  logic [7:0] stat;

  modport slv (output wr, addr, wdata, input ctrl, stat);
  modport core (input wr, addr, wdata, output ctrl, stat);
endinterface

//--- core/wdc_avs.sv
/*
  Avalon-MM slave with waitrequest for the watchdog registers.
  Assumes byte addresses, one register per 32-bit word.
*/
`timescale 1ns/1ns
module wdc_avs
  import wdc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic avs_waitrequest,
  output logic [31:0] avs_readdata,
  // Register side
  wdc_reg_if.slv rif
);

  function automatic logic [31:0] rd_word(input logic [7:0] a,
                                          input logic [7:0] c,
                                          input logic [7:0] s);
    if (a == CTRL_ADDR) begin
      return {24'h000000, c};
    end else if (a == STAT_ADDR) begin
      return {24'h000000, s};
    end
    return 32'h00000000;
  endfunction

  // One wait cycle, then the answer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      if (avs_read) begin
        avs_readdata <= rd_word(avs_address, rif.ctrl, rif.stat);
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  assign rif.wr = avs_write && !avs_waitrequest;
  assign rif.addr = avs_address;
  assign rif.wdata = avs_writedata[7:0];

endmodule // wdc_avs

//--- core/wdc_tick.sv
/*
  Watchdog time base: tick divider and period counter.
  Assumes kick comes from logic on clk_sys.
*/
`timescale 1ns/1ns
module wdc_tick
  import wdc_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned BASE = BASE_TICKS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Control
  input wire logic kick,
  input wire logic [3:0] sel,
  // Event
  output logic tmo
);

  logic [15:0] div;
  logic tick;
  logic [31:0] cnt;
  logic [3:0] sel_c;
  logic [31:0] term;

  assign tick = (div == 16'(TICK_DIV - 1));
  assign sel_c = (sel > MAX_SEL) ? MAX_SEL : sel;
  assign term = (32'(BASE) << sel_c) - 32'h00000001;

  always_ff @(posedge clk_sys) begin
    if (srst || kick || tick) begin
      div <= 16'h0000;
    end else begin
      div <= div + 16'h0001;
    end
  end

  // Count ticks up to the selected terminal, then restart
  always_ff @(posedge clk_sys) begin
    if (srst || kick) begin
      cnt <= 32'h00000000;
      tmo <= 1'b0;
    end else begin
      tmo <= 1'b0;
      if (tick && cnt >= term) begin
        cnt <= 32'h00000000;
        tmo <= 1'b1;
      end else if (tick) begin
        cnt <= cnt + 32'h00000001;
      end
    end
  end

  property p_restart;
    @(posedge clk_sys) disable iff (srst)
    tmo |-> (cnt == 32'h00000000) && !$past(tmo);
  endproperty
  a_restart: assert property (p_restart)
    else $error("timeout without counter restart");

endmodule // wdc_tick

//--- core/wdc_top.sv
/*
  Watchdog mode control: control register, time-out actions,
  interrupt request and change-unlock window.
  Assumes cpu_gie, vector_ack and wdt_kick come from logic on
  clk_sys; force_reset_fuse is a static pin level.
*/
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ns

// Function
// - Timeout sets flag bit 7 when watchdog is set for interrupt.
// - Taking the interrupt vector clears the flag in hardware.
// - Writing one to the flag clears it; zero leaves it.
// - Interrupt requested only when flag, enable bit 6 and global enable set.
// - Unprogrammed fuse, both enables zero: nothing; programmed fuse: reset.
// - Only interrupt enable set: interrupt on each timeout, no reset.
// - Only reset enable set: reset on timeout, no interrupt.
// - Both enables set: first timeout sets flag instead of resetting.
// - Combined mode: vector clears enable and flag, leaving reset mode.
// - Combined mode: timeout with interrupt still pending resets system.
// - Clearing reset enable or changing period needs unlock bit 4 set.
// - Unlock bit clears itself four clock cycles after being written.
// - Control register resets to zero except reset enable bit 3.
// - Flag set while its enable is clear stays set until handled.
// - Flags set with global interrupts off stay pending until enabled.
module wdc_top
  import wdc_pkg::*;
#(
  parameter logic RSTEN_INIT = 1'b0,
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned BASE = BASE_TICKS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic avs_waitrequest,
  output logic [31:0] avs_readdata,
  // Processor side
  input wire logic cpu_gie,
  input wire logic vector_ack,
  input wire logic wdt_kick,
  // Fuse pin
  input wire logic force_reset_fuse,
  // Requests
  output logic irq_req,
  output logic sys_reset_req
);

  function automatic wdc_mode_t mode_dec(input logic fuse,
                                         input logic rst_en,
                                         input logic irq_en);
    if (!fuse) begin
      return MODE_RST;
    end
    case ({rst_en, irq_en})
      2'b01: return MODE_IRQ;
      2'b10: return MODE_RST;
      2'b11: return MODE_BOTH;
      default: return MODE_STOP;
    endcase
  endfunction

  // ********************************
  // Declarations
  // ********************************
  wdc_reg_if rif ();

  logic fuse_meta;
  logic fuse_sync;
  logic timeout_flag;
  logic timeout_irq_enable;
  logic reset_on_timeout_enable;
  logic change_unlock;
  logic [2:0] unl_cnt;
  logic [3:0] period_sel;
  logic tmo;
  logic wr_ctrl;
  logic unl_wr;
  logic set_flag;
  logic rst_now;
  logic clr_ie;
  wdc_mode_t mode;

  // ********************************
  // Submodules
  // ********************************
  wdc_avs u_avs (
    .clk_sys(clk_sys),
    .srst(srst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata),
    .rif(rif.slv)
  );

  wdc_tick #(
    .TICK_DIV(TICK_DIV),
    .BASE(BASE)
  ) u_tick (
    .clk_sys(clk_sys),
    .srst(srst),
    .kick(wdt_kick),
    .sel(period_sel),
    .tmo(tmo)
  );

  // ********************************
  // Fuse synchroniser
  // ********************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fuse_meta <= 1'b1;
      fuse_sync <= 1'b1;
    end else begin
      fuse_meta <= force_reset_fuse;
      fuse_sync <= fuse_meta;
    end
  end

  // ********************************
  // Decode
  // ********************************
  assign mode = mode_dec(fuse_sync, reset_on_timeout_enable,
                         timeout_irq_enable);
  assign wr_ctrl = rif.wr && (rif.addr == CTRL_ADDR);
  assign unl_wr = wr_ctrl && rif.wdata[UNL_BIT];
  // Flag only in modes that interrupt; pending flag in combined escalates
  assign set_flag = tmo && (mode == MODE_IRQ ||
                    (mode == MODE_BOTH && !timeout_flag));
  assign rst_now = tmo && (mode == MODE_RST ||
                   (mode == MODE_BOTH && timeout_flag));
  assign clr_ie = vector_ack && (mode == MODE_BOTH);

  // ********************************
  // Time-out flag
  // ********************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      timeout_flag <= CTRL_RESET[FLAG_BIT];
    end else if (set_flag) begin
      timeout_flag <= 1'b1;
    end else if (vector_ack) begin
      timeout_flag <= 1'b0;
    end else if (wr_ctrl && rif.wdata[FLAG_BIT]) begin
      timeout_flag <= 1'b0;
    end
  end

  // ********************************
  // Interrupt enable
  // ********************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      timeout_irq_enable <= CTRL_RESET[IE_BIT];
    end else if (wr_ctrl && rif.wdata[IE_BIT]) begin
      timeout_irq_enable <= 1'b1;
    end else if (clr_ie || wr_ctrl) begin
      timeout_irq_enable <= 1'b0;
    end
  end

  // ********************************
  // Protected fields
  // ********************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reset_on_timeout_enable <= RSTEN_INIT;
    end else if (wr_ctrl && (rif.wdata[RSTEN_BIT] || change_unlock)) begin
      reset_on_timeout_enable <= rif.wdata[RSTEN_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      period_sel <= {CTRL_RESET[P3_BIT], CTRL_RESET[P_HI:P_LO]};
    end else if (wr_ctrl && change_unlock) begin
      period_sel <= {rif.wdata[P3_BIT], rif.wdata[P_HI:P_LO]};
    end
  end

  // ********************************
  // Change-unlock window
  // ********************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      change_unlock <= CTRL_RESET[UNL_BIT];
      unl_cnt <= 3'h0;
    end else if (unl_wr) begin
      change_unlock <= 1'b1;
      unl_cnt <= UNLOCK_CYCLES - 3'h1;
    end else if (change_unlock && unl_cnt == 3'h0) begin
      change_unlock <= 1'b0;
    end else if (change_unlock) begin
      unl_cnt <= unl_cnt - 3'h1;
    end
  end

  // ********************************
  // Requests
  // ********************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_req <= 1'b0;
    end else begin
      // Pending flag waits for global enable
      irq_req <= timeout_flag && timeout_irq_enable && cpu_gie;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= rst_now;
    end
  end

  // ********************************
  // Readback
  // ********************************
  assign rif.ctrl = {timeout_flag, timeout_irq_enable, period_sel[3],
                     change_unlock, reset_on_timeout_enable,
                     period_sel[2:0]};
  assign rif.stat = {6'h00, irq_req, fuse_sync};

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  sequence s_unl_arm;
    unl_wr;
  endsequence

  sequence s_unl_quiet;
    (!unl_wr) [*4];
  endsequence

  property p_flag_set;
    (tmo && fuse_sync && timeout_irq_enable && !timeout_flag)
      |=> timeout_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("timeout did not set flag");

  property p_flag_vec;
    (vector_ack && !set_flag) |=> !timeout_flag;
  endproperty
  a_flag_vec: assert property (p_flag_vec)
    else $error("vector did not clear flag");

  property p_flag_w1c;
    (wr_ctrl && !set_flag && !vector_ack)
      |=> (timeout_flag == ($past(timeout_flag) &&
                            !$past(rif.wdata[FLAG_BIT])));
  endproperty
  a_flag_w1c: assert property (p_flag_w1c)
    else $error("flag write one to clear broken");

  property p_irq;
    1'b1 |=> irq_req == ($past(timeout_flag) && $past(timeout_irq_enable) &&
                         $past(cpu_gie));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request gating wrong");

  // Vector or software clear may still legally move a stale flag
  property p_stop;
    (tmo && mode == MODE_STOP && !vector_ack && !wr_ctrl)
      |=> !sys_reset_req && $stable(timeout_flag);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stopped mode acted on timeout");

  property p_fuse;
    (tmo && !fuse_sync) |=> sys_reset_req;
  endproperty
  a_fuse: assert property (p_fuse)
    else $error("programmed fuse did not force reset");

  property p_irq_mode;
    (tmo && mode == MODE_IRQ) |=> timeout_flag && !sys_reset_req;
  endproperty
  a_irq_mode: assert property (p_irq_mode)
    else $error("interrupt mode misbehaved");

  property p_rst_mode;
    (tmo && mode == MODE_RST && !timeout_flag)
      |=> sys_reset_req && !irq_req ##1 !sys_reset_req;
  endproperty
  a_rst_mode: assert property (p_rst_mode)
    else $error("reset mode misbehaved");

  property p_both_first;
    (tmo && mode == MODE_BOTH && !timeout_flag)
      |=> timeout_flag && !sys_reset_req;
  endproperty
  a_both_first: assert property (p_both_first)
    else $error("first combined timeout reset the system");

  property p_both_vec;
    (clr_ie && !(wr_ctrl && rif.wdata[IE_BIT]) && !tmo)
      |=> !timeout_irq_enable && !timeout_flag;
  endproperty
  a_both_vec: assert property (p_both_vec)
    else $error("vector did not leave combined mode");

  property p_both_second;
    (tmo && mode == MODE_BOTH && timeout_flag) |=> sys_reset_req;
  endproperty
  a_both_second: assert property (p_both_second)
    else $error("pending combined timeout did not reset");

  property p_lock;
    (wr_ctrl && !change_unlock)
      |=> $stable(period_sel) &&
          (reset_on_timeout_enable || !$past(reset_on_timeout_enable));
  endproperty
  a_lock: assert property (p_lock)
    else $error("protected field changed while locked");

  property p_unl_hold;
    s_unl_arm |=> change_unlock [*4];
  endproperty
  a_unl_hold: assert property (p_unl_hold)
    else $error("unlock window shorter than four cycles");

  property p_unl_close;
    s_unl_arm ##1 s_unl_quiet |=> !change_unlock;
  endproperty
  a_unl_close: assert property (p_unl_close)
    else $error("unlock window did not close");

  property p_reset_val;
    $fell(srst) |-> rif.ctrl[7:4] == 4'h0 && rif.ctrl[2:0] == 3'h0;
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("control register reset value wrong");

  property p_hold;
    (timeout_flag && !vector_ack && !(wr_ctrl && rif.wdata[FLAG_BIT]))
      |=> timeout_flag;
  endproperty
  a_hold: assert property (p_hold)
    else $error("pending flag lost");

endmodule // wdc_top

//--- dv/wdc_top_tb_top.sv
/*
  Self-checking bench for the watchdog mode control block.
  Assumes wdc_top with an Avalon-MM slave, one wait cycle per access,
  and shortened time base: 256 cycles per time-out at period select 4.
*/
`timescale 1ns/1ns
module wdc_top_tb_top
  import wdc_pkg::*;
;
  // ********************************
  // Signals
  // ********************************
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic avs_waitrequest;
  logic [31:0] avs_readdata;
  logic cpu_gie = 1'b0;
  logic vector_ack = 1'b0;
  logic wdt_kick = 1'b0;
  logic force_reset_fuse = 1'b1;
  logic irq_req;
  logic sys_reset_req;
  int n_errors = 0;
  int cmp_count = 0;
  logic [7:0] n_rst = 8'h00;
  logic [7:0] base_rst = 8'h00;

  always #5 clk_sys = ~clk_sys;

  // Count reset request pulses
  always @(posedge clk_sys) begin
    if (sys_reset_req === 1'b1) n_rst <= n_rst + 8'h01;
  end

  wdc_top #(.RSTEN_INIT(1'b0), .TICK_DIV(2), .BASE(8)) dut (
    .clk_sys(clk_sys), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .cpu_gie(cpu_gie), .vector_ack(vector_ack), .wdt_kick(wdt_kick),
    .force_reset_fuse(force_reset_fuse),
    .irq_req(irq_req), .sys_reset_req(sys_reset_req)
  );

  // ********************************
  // Helpers
  // ********************************
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t level %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One access; holds until waitrequest is sampled low
  task automatic bus_xfer(input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q);
    int i;
    i = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk_sys);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (i >= 20) begin
      n_errors++;
      $display("BAD %0t bus access hung", $time);
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] exp);
    logic [7:0] q;
    bus_xfer(1'b0, a, 8'h00, q);
    chk_byte(q & m, exp);
  endtask

  task automatic pulse(input logic vec);
    @(posedge clk_sys);
    if (vec) vector_ack <= 1'b1;
    else wdt_kick <= 1'b1;
    @(posedge clk_sys);
    vector_ack <= 1'b0;
    wdt_kick <= 1'b0;
    if (!vec) base_rst = n_rst;
  endtask

  task automatic print_verdict;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset;
    rd_chk(CTRL_ADDR, 8'hFF, 8'h00);
    rd_chk(STAT_ADDR, 8'h03, 8'h01);
    bus_write(8'h20, 8'hFF);
    rd_chk(8'h20, 8'hFF, 8'h00);
    rd_chk(CTRL_ADDR, 8'hFF, 8'h00);
  endtask

  task automatic t_protect;
    pulse(1'b0);
    bus_write(CTRL_ADDR, 8'h04);
    rd_chk(CTRL_ADDR, 8'hEF, 8'h00);
    bus_write(CTRL_ADDR, 8'h10);
    rd_chk(CTRL_ADDR, 8'h10, 8'h10);
    wait_cyc(8);
    rd_chk(CTRL_ADDR, 8'h10, 8'h00);
    bus_write(CTRL_ADDR, 8'h10);
    bus_write(CTRL_ADDR, 8'h04);
    rd_chk(CTRL_ADDR, 8'hEF, 8'h04);
    bus_write(CTRL_ADDR, 8'h0C);
    rd_chk(CTRL_ADDR, 8'hEF, 8'h0C);
    wait_cyc(8);
    bus_write(CTRL_ADDR, 8'h04);
    rd_chk(CTRL_ADDR, 8'hEF, 8'h0C);
    bus_write(CTRL_ADDR, 8'h14);
    bus_write(CTRL_ADDR, 8'h04);
    rd_chk(CTRL_ADDR, 8'hEF, 8'h04);
  endtask

  task automatic t_stop;
    pulse(1'b0);
    wait_cyc(300);
    chk_byte(n_rst - base_rst, 8'h00);
    rd_chk(CTRL_ADDR, 8'hEF, 8'h04);
  endtask

  task automatic t_irq;
    bus_write(CTRL_ADDR, 8'h44);
    pulse(1'b0);
    wait_cyc(300);
    rd_chk(CTRL_ADDR, 8'hEF, 8'hC4);
    chk_bit(irq_req, 1'b0);
    bus_write(CTRL_ADDR, 8'h44);
    rd_chk(CTRL_ADDR, 8'hEF, 8'hC4);
    @(posedge clk_sys);
    cpu_gie <= 1'b1;
    wait_cyc(3);
    chk_bit(irq_req, 1'b1);
    rd_chk(STAT_ADDR, 8'h02, 8'h02);
    pulse(1'b1);
    wait_cyc(3);
    chk_bit(irq_req, 1'b0);
    rd_chk(CTRL_ADDR, 8'hEF, 8'h44);
    wait_cyc(250);
    chk_bit(irq_req, 1'b1);
    bus_write(CTRL_ADDR, 8'hC4);
    wait_cyc(3);
    chk_bit(irq_req, 1'b0);
    rd_chk(CTRL_ADDR, 8'hEF, 8'h44);
    chk_byte(n_rst - base_rst, 8'h00);
    cpu_gie <= 1'b0;
  endtask

  task automatic t_rstmode;
    bus_write(CTRL_ADDR, 8'h0C);
    pulse(1'b0);
    wait_cyc(300);
    chk_byte(n_rst - base_rst, 8'h01);
    rd_chk(CTRL_ADDR, 8'hEF, 8'h0C);
    chk_bit(irq_req, 1'b0);
  endtask

  task automatic t_both;
    bus_write(CTRL_ADDR, 8'h4C);
    pulse(1'b0);
    wait_cyc(300);
    rd_chk(CTRL_ADDR, 8'hEF, 8'hCC);
    chk_byte(n_rst - base_rst, 8'h00);
    wait_cyc(256);
    chk_byte(n_rst - base_rst, 8'h01);
    bus_write(CTRL_ADDR, 8'hCC);
    pulse(1'b0);
    wait_cyc(300);
    rd_chk(CTRL_ADDR, 8'hEF, 8'hCC);
    pulse(1'b1);
    rd_chk(CTRL_ADDR, 8'hEF, 8'h0C);
    wait_cyc(300);
    chk_byte(n_rst - base_rst, 8'h01);
  endtask

  task automatic t_fuse;
    bus_write(CTRL_ADDR, 8'h14);
    bus_write(CTRL_ADDR, 8'h44);
    @(posedge clk_sys);
    force_reset_fuse <= 1'b0;
    wait_cyc(5);
    rd_chk(STAT_ADDR, 8'h01, 8'h00);
    pulse(1'b0);
    wait_cyc(300);
    chk_byte(n_rst - base_rst, 8'h01);
    rd_chk(CTRL_ADDR, 8'hEF, 8'h44);
    force_reset_fuse <= 1'b1;
    wait_cyc(5);
    rd_chk(STAT_ADDR, 8'h01, 8'h01);
  endtask

  // ********************************
  // Sequence and watchdog
  // ********************************
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_protect();
    t_stop();
    t_irq();
    t_rstmode();
    t_both();
    t_fuse();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    print_verdict();
  end
endmodule // wdc_top_tb_top
